// [rtl/tcis_pkg.sv]
// tcis_pkg: constants, types and device register map for the touch panel host
// assumes a 50 MHz system clock; all pins of the touch controller are open drain or plain
package tcis_pkg;

    // device slave addresses, write and read forms
    localparam logic [7:0] TCIS_ADDR_W_PRI = 8'hba;
    localparam logic [7:0] TCIS_ADDR_R_PRI = 8'hbb;
    localparam logic [7:0] TCIS_ADDR_W_ALT = 8'h28;
    localparam logic [7:0] TCIS_ADDR_R_ALT = 8'h29;

    // device register map
    localparam logic [15:0] TCIS_REG_TOUCH_REPORT_STATUS   = 16'h814e;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_TAG       = 16'h814f;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_X_LOW     = 16'h8150;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_X_HIGH    = 16'h8151;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_Y_LOW     = 16'h8152;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_Y_HIGH    = 16'h8153;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_SIZE_LOW  = 16'h8154;
    localparam logic [15:0] TCIS_REG_FIRST_POINT_SIZE_HIGH = 16'h8155;
    localparam logic [15:0] TCIS_REG_RESERVED_AFTER_POINT  = 16'h8156;

    // status byte fields
    localparam int TCIS_STAT_READY_BIT = 7;
    localparam int TCIS_STAT_LARGE_BIT = 6;
    localparam int TCIS_STAT_COUNT_MSB = 3;
    localparam int TCIS_STAT_COUNT_LSB = 0;

    // bus timing; one bit is four quarters, scl low two, scl high two
    localparam int TCIS_CLK_PERIOD_NS   = 20;
    localparam int TCIS_SCL_LOW_MIN_NS  = 1300;
    localparam int TCIS_QUARTER_NS      = TCIS_SCL_LOW_MIN_NS / 2;
    localparam int TCIS_QUARTER_CYC     = (TCIS_QUARTER_NS + TCIS_CLK_PERIOD_NS - 1) / TCIS_CLK_PERIOD_NS;

    // power-on address select timing
    localparam int TCIS_POR_RST_NS      = 10000;
    localparam int TCIS_POR_RST_CYC     = (TCIS_POR_RST_NS + TCIS_CLK_PERIOD_NS - 1) / TCIS_CLK_PERIOD_NS;
    localparam int TCIS_POR_HOLD_NS     = 5000000;
    localparam int TCIS_POR_HOLD_CYC    = (TCIS_POR_HOLD_NS + TCIS_CLK_PERIOD_NS - 1) / TCIS_CLK_PERIOD_NS;

    localparam int TCIS_BIT_ACK         = 8;
    localparam int TCIS_SYNC_RESET      = 1;

    typedef enum logic [2:0] {
        TCIS_POR_RST  = 3'b000,
        TCIS_POR_HOLD = 3'b001,
        TCIS_IDLE     = 3'b011,
        TCIS_START    = 3'b010,
        TCIS_BYTE     = 3'b110,
        TCIS_STOP     = 3'b111
    } tcis_state_t;

    typedef enum logic [2:0] {
        TCIS_STG_ADDR_W = 3'b000,
        TCIS_STG_REG_HI = 3'b001,
        TCIS_STG_REG_LO = 3'b011,
        TCIS_STG_WDATA  = 3'b010,
        TCIS_STG_ADDR_R = 3'b110,
        TCIS_STG_RDATA  = 3'b111
    } tcis_stage_t;

    typedef struct packed {
        logic        rd;
        logic [15:0] reg_addr;
        logic [7:0]  len;
    } tcis_cmd_t;

endpackage : tcis_pkg

// [rtl/tcis_sync.sv]
// tcis_sync: two-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to clk_in; resets to the idle-high level
`timescale 1ns/1ps
module tcis_sync
    import tcis_pkg::*;
#(
    parameter int W = 3
)(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk_in)
            begin
                if (sys_rst_in)
                begin
                    meta_ff <= 1'(TCIS_SYNC_RESET);
                    sync_ff <= 1'(TCIS_SYNC_RESET);
                end
                else
                begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign sync_out[i] = sync_ff;
        end
    endgenerate

endmodule // tcis_sync

// [rtl/tcis_host.sv]
// tcis_host: bus master that configures and accesses the touch panel controller
// assumes open-drain scl/sda with pull-ups resolved outside; int pin two-way
`timescale 1ns/1ps
module tcis_host
    import tcis_pkg::*;
#(
    parameter int QUARTER_CYC  = TCIS_QUARTER_CYC,
    parameter int POR_RST_CYC  = TCIS_POR_RST_CYC,
    parameter int POR_HOLD_CYC = TCIS_POR_HOLD_CYC
)(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // power-on address choice
    input  wire logic       addr_sel_in,
    // user command port
    input  wire tcis_cmd_t  cmd_in,
    input  wire logic       cmd_valid_in,
    output logic            cmd_ready_out,
    input  wire logic [7:0] wr_data_in,
    output logic            wr_next_out,
    output logic [7:0]      rd_data_out,
    output logic            rd_valid_out,
    output logic            done_out,
    output logic            nack_err_out,
    output logic            attn_out,
    output logic            addr_alt_out,
    // touch controller pins
    output logic            scl_out,
    output logic            scl_oe_out,
    input  wire logic       scl_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       sda_in,
    output logic            int_out,
    output logic            int_oe_out,
    input  wire logic       int_in,
    output logic            tp_rst_n_out
);

    tcis_state_t state_ff;
    tcis_stage_t stage_ff;
    tcis_cmd_t   cmd_ff;
    logic [5:0]  q_cnt_ff;
    logic [1:0]  phase_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  shift_ff;
    logic [7:0]  remain_ff;
    logic [19:0] por_cnt_ff;
    logic        alt_ff;
    logic [2:0]  pin_sync;
    logic        scl_s;
    logic        sda_s;
    logic        int_s;
    logic        stretch;
    logic        q_end;
    logic        bit_end;
    logic        is_rx;
    logic        nxt_scl_drv;
    logic        nxt_sda_drv;

    tcis_sync #(
        .W (3)
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({int_in, sda_in, scl_in}),
        .sync_out   (pin_sync)
    );

    assign scl_s   = pin_sync[0];
    assign sda_s   = pin_sync[1];
    assign int_s   = pin_sync[2];
    assign is_rx   = (stage_ff == TCIS_STG_RDATA);
    // wait for scl to really rise before timing its high period
    assign stretch = (phase_ff == 2'd2) && !scl_s && !scl_oe_out;
    assign q_end   = (q_cnt_ff == 6'(QUARTER_CYC - 1)) && !stretch;
    assign bit_end = q_end && (phase_ff == 2'd3);

    // quarter-bit timing, keeps rate under the bus limit
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || state_ff == TCIS_IDLE || state_ff == TCIS_POR_RST || state_ff == TCIS_POR_HOLD)
        begin
            q_cnt_ff <= 6'h00;
            phase_ff <= 2'h0;
        end
        else if (q_end)
        begin
            q_cnt_ff <= 6'h00;
            phase_ff <= phase_ff + 2'h1;
        end
        else if (!stretch)
        begin
            q_cnt_ff <= q_cnt_ff + 6'h01;
        end
    end

    // power-on address select sequence
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            alt_ff       <= 1'b0;
            por_cnt_ff   <= 20'h00000;
            tp_rst_n_out <= 1'b0;
            int_oe_out   <= 1'b0;
            int_out      <= 1'b0;
        end
        else if (state_ff == TCIS_POR_RST)
        begin
            if (por_cnt_ff == 20'h00000)
            begin
                alt_ff <= addr_sel_in;
            end
            int_oe_out   <= 1'b1;
            int_out      <= (por_cnt_ff == 20'h00000) ? addr_sel_in : alt_ff;
            tp_rst_n_out <= 1'b0;
            por_cnt_ff   <= (por_cnt_ff == 20'(POR_RST_CYC - 1)) ? 20'h00000 : por_cnt_ff + 20'h00001;
        end
        else if (state_ff == TCIS_POR_HOLD)
        begin
            tp_rst_n_out <= 1'b1;
            por_cnt_ff   <= por_cnt_ff + 20'h00001;
            if (por_cnt_ff == 20'(POR_HOLD_CYC - 1))
            begin
                int_oe_out <= 1'b0;
            end
        end
    end

    // main sequencer
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= TCIS_POR_RST;
            stage_ff <= TCIS_STG_ADDR_W;
            cmd_ff   <= '0;
            bit_ff   <= 4'h0;
            shift_ff <= 8'h00;
            remain_ff <= 8'h00;
        end
        else
        begin
            case (state_ff)
                TCIS_POR_RST:
                begin
                    if (por_cnt_ff == 20'(POR_RST_CYC - 1))
                    begin
                        state_ff <= TCIS_POR_HOLD;
                    end
                end
                TCIS_POR_HOLD:
                begin
                    if (por_cnt_ff == 20'(POR_HOLD_CYC - 1))
                    begin
                        state_ff <= TCIS_IDLE;
                    end
                end
                TCIS_IDLE:
                begin
                    if (cmd_valid_in && cmd_in.len != 8'h00)
                    begin
                        cmd_ff    <= cmd_in;
                        remain_ff <= cmd_in.len;
                        stage_ff  <= TCIS_STG_ADDR_W;
                        shift_ff  <= alt_ff ? TCIS_ADDR_W_ALT : TCIS_ADDR_W_PRI;
                        bit_ff    <= 4'h0;
                        state_ff  <= TCIS_START;
                    end
                end
                TCIS_START:
                begin
                    if (bit_end)
                    begin
                        bit_ff   <= 4'h0;
                        state_ff <= TCIS_BYTE;
                    end
                end
                TCIS_BYTE:
                begin
                    if (bit_end && bit_ff != 4'(TCIS_BIT_ACK))
                    begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bit_ff   <= bit_ff + 4'h1;
                    end
                    else if (bit_end)
                    begin
                        bit_ff <= 4'h0;
                        if (!is_rx && sda_s)
                        begin
                            state_ff <= TCIS_STOP;
                        end
                        else
                        begin
                            case (stage_ff)
                                TCIS_STG_ADDR_W:
                                begin
                                    stage_ff <= TCIS_STG_REG_HI;
                                    shift_ff <= cmd_ff.reg_addr[15:8];
                                end
                                TCIS_STG_REG_HI:
                                begin
                                    stage_ff <= TCIS_STG_REG_LO;
                                    shift_ff <= cmd_ff.reg_addr[7:0];
                                end
                                TCIS_STG_REG_LO:
                                begin
                                    if (cmd_ff.rd)
                                    begin
                                        stage_ff <= TCIS_STG_ADDR_R;
                                        shift_ff <= alt_ff ? TCIS_ADDR_R_ALT : TCIS_ADDR_R_PRI;
                                        state_ff <= TCIS_START;
                                    end
                                    else
                                    begin
                                        stage_ff <= TCIS_STG_WDATA;
                                        shift_ff <= wr_data_in;
                                    end
                                end
                                TCIS_STG_ADDR_R:
                                begin
                                    stage_ff <= TCIS_STG_RDATA;
                                    shift_ff <= 8'h00;
                                end
                                default:
                                begin
                                    remain_ff <= remain_ff - 8'h01;
                                    shift_ff  <= wr_data_in;
                                    if (remain_ff == 8'h01)
                                    begin
                                        state_ff <= TCIS_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
                TCIS_STOP:
                begin
                    if (bit_end)
                    begin
                        state_ff <= TCIS_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= TCIS_IDLE;
                end
            endcase
        end
    end

    // pin drive per state and quarter
    always_comb
    begin
        nxt_scl_drv = 1'b0;
        nxt_sda_drv = 1'b0;
        case (state_ff)
            TCIS_START:
            begin
                nxt_scl_drv = (phase_ff < 2'd2);
                nxt_sda_drv = (phase_ff == 2'd0) ? sda_oe_out : (phase_ff == 2'd3);
            end
            TCIS_BYTE:
            begin
                nxt_scl_drv = (phase_ff < 2'd2);
                if (phase_ff == 2'd0)
                begin
                    nxt_sda_drv = sda_oe_out;
                end
                else if (bit_ff != 4'(TCIS_BIT_ACK))
                begin
                    nxt_sda_drv = !is_rx && !shift_ff[7];
                end
                else
                begin
                    nxt_sda_drv = is_rx && (remain_ff != 8'h01);
                end
            end
            TCIS_STOP:
            begin
                nxt_scl_drv = (phase_ff < 2'd2);
                nxt_sda_drv = (phase_ff == 2'd0) ? sda_oe_out : (phase_ff != 2'd3);
            end
            default:
            begin
                nxt_scl_drv = 1'b0;
                nxt_sda_drv = 1'b0;
            end
        endcase
    end

    // registered pin outputs
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
            scl_out    <= 1'b0;
            sda_out    <= 1'b0;
        end
        else
        begin
            scl_oe_out <= nxt_scl_drv;
            sda_oe_out <= nxt_sda_drv;
            scl_out    <= 1'b0;
            sda_out    <= 1'b0;
        end
    end

    // user-side status and strobes
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cmd_ready_out <= 1'b0;
            wr_next_out   <= 1'b0;
            rd_data_out   <= 8'h00;
            rd_valid_out  <= 1'b0;
            done_out      <= 1'b0;
            nack_err_out  <= 1'b0;
            attn_out      <= 1'b0;
            addr_alt_out  <= 1'b0;
        end
        else
        begin
            cmd_ready_out <= (state_ff == TCIS_IDLE) && !(cmd_valid_in && cmd_in.len != 8'h00);
            wr_next_out   <= bit_end && bit_ff == 4'(TCIS_BIT_ACK) && !sda_s && !cmd_ff.rd &&
                             (stage_ff == TCIS_STG_REG_LO || stage_ff == TCIS_STG_WDATA);
            rd_valid_out  <= bit_end && bit_ff == 4'(TCIS_BIT_ACK) && is_rx;
            if (bit_end && bit_ff == 4'(TCIS_BIT_ACK) && is_rx)
            begin
                rd_data_out <= shift_ff;
            end
            done_out <= (state_ff == TCIS_STOP) && bit_end;
            if (state_ff == TCIS_IDLE && cmd_valid_in && cmd_in.len != 8'h00)
            begin
                nack_err_out <= 1'b0;
            end
            else if (state_ff == TCIS_BYTE && bit_end && bit_ff == 4'(TCIS_BIT_ACK) && !is_rx && sda_s)
            begin
                nack_err_out <= 1'b1;
            end
            attn_out     <= !int_s && !int_oe_out && (state_ff != TCIS_POR_RST) && (state_ff != TCIS_POR_HOLD);
            addr_alt_out <= alt_ff;
        end
    end

endmodule // tcis_host

// [testbench/tcis_host_monitor.sv]
// tcis_host_monitor: concurrent checks on the touch panel host ports
// assumes bind into tcis_host; clk_in domain only
`timescale 1ns/1ps
module tcis_host_monitor
    import tcis_pkg::*;
#(
    parameter int QUARTER_CYC = TCIS_QUARTER_CYC
)(
    // clock and reset
    input  wire logic      clk_in,
    input  wire logic      sys_rst_in,
    // user side
    input  wire logic      addr_sel_in,
    input  wire tcis_cmd_t cmd_in,
    input  wire logic      cmd_valid_in,
    input  wire logic      cmd_ready_out,
    input  wire logic      wr_next_out,
    input  wire logic      rd_valid_out,
    input  wire logic      done_out,
    input  wire logic      nack_err_out,
    input  wire logic      attn_out,
    input  wire logic      addr_alt_out,
    // pins
    input  wire logic      scl_oe_out,
    input  wire logic      scl_in,
    input  wire logic      sda_oe_out,
    input  wire logic      int_out,
    input  wire logic      int_oe_out,
    input  wire logic      int_in,
    input  wire logic      tp_rst_n_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    logic        take;
    logic [15:0] lo_cnt_ff;
    logic [15:0] hi_cnt_ff;
    logic [7:0]  n_ff;
    logic [7:0]  len_ff;

    assign take = cmd_ready_out && cmd_valid_in && (cmd_in.len != 8'h00);

    always_ff @(posedge clk_in)
        lo_cnt_ff <= scl_oe_out ? lo_cnt_ff + 16'h0001 : 16'h0000;

    always_ff @(posedge clk_in)
        hi_cnt_ff <= (!scl_oe_out && scl_in) ? hi_cnt_ff + 16'h0001 : 16'h0000;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            n_ff <= 8'h00;
        else if (take)
            n_ff <= 8'h00;
        else if (rd_valid_out || wr_next_out)
            n_ff <= n_ff + 8'h01;
    end

    always_ff @(posedge clk_in)
        if (take)
            len_ff <= cmd_in.len + 8'(!cmd_in.rd);

    AST_POR_ADDR: assert property (int_oe_out && !tp_rst_n_out |-> int_out == addr_sel_in)
        else $error("int level wrong while touch reset held");
    AST_POR_HANDOFF: assert property ($rose(tp_rst_n_out) |-> int_oe_out && int_out == addr_alt_out)
        else $error("address level not held at reset release");
    AST_START: assert property ($rose(sda_oe_out) && !scl_oe_out |-> ##[1:40] $rose(scl_oe_out))
        else $error("start not followed by clock low");
    AST_STOP_DONE: assert property ($fell(sda_oe_out) && !scl_oe_out && !$past(scl_oe_out)
        |-> ##[0:60] done_out)
        else $error("sda rose in clock high without stop");
    AST_SCL_LOW: assert property ($fell(scl_oe_out) |-> lo_cnt_ff >= 16'(2 * QUARTER_CYC))
        else $error("clock low period too short");
    AST_SCL_HIGH: assert property ($rose(scl_oe_out) |-> hi_cnt_ff >= 16'(QUARTER_CYC))
        else $error("clock high period too short");
    AST_TAKE: assert property (take |=> !cmd_ready_out ##[0:40] sda_oe_out)
        else $error("taken command did not start");
    AST_LEN0: assert property (cmd_ready_out && cmd_valid_in && cmd_in.len == 8'h00 |=> cmd_ready_out)
        else $error("empty command taken");
    AST_XFER_COUNT: assert property (done_out && !nack_err_out |-> n_ff == len_ff)
        else $error("byte count differs from length");
    AST_NACK_STOP: assert property ($rose(nack_err_out) |-> ##[1:100] done_out)
        else $error("no stop after refused byte");
    AST_ATTN: assert property ((!int_oe_out && !int_in) [*5] |-> attn_out)
        else $error("attention not reported");

    cover property (done_out && nack_err_out);
    cover property ($rose(attn_out));
    cover property (rd_valid_out && !nack_err_out);
endmodule // tcis_host_monitor

bind tcis_host tcis_host_monitor #(.QUARTER_CYC(QUARTER_CYC)) i_mon (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_sel_in(addr_sel_in), .cmd_in(cmd_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .wr_next_out(wr_next_out),
    .rd_valid_out(rd_valid_out), .done_out(done_out), .nack_err_out(nack_err_out),
    .attn_out(attn_out), .addr_alt_out(addr_alt_out), .scl_oe_out(scl_oe_out), .scl_in(scl_in),
    .sda_oe_out(sda_oe_out), .int_out(int_out), .int_oe_out(int_oe_out), .int_in(int_in),
    .tp_rst_n_out(tp_rst_n_out));

// [testbench/tcis_dev_model.sv]
// tcis_dev_model: behavioural touch controller, register slave on scl/sda
// assumes wired-and lines with pull-ups resolved in the bench
`timescale 1ns/1ps
module tcis_dev_model
    import tcis_pkg::*;
(
    // wires
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic int_in,
    input  wire logic rst_n_in,
    output logic      scl_pull_out,
    output logic      sda_pull_out,
    output logic      int_pull_out,
    // fault and pace
    input  wire logic mute_in,
    input  wire logic slow_in
);
    logic [7:0]  mem [9];
    logic [7:0]  sh;
    logic [7:0]  b;
    logic [15:0] ptr;
    logic [3:0]  cnt;
    logic [2:0]  ph;
    logic        alt;
    logic [7:0]  aw;
    logic [7:0]  ar;

    assign aw = alt ? TCIS_ADDR_W_ALT : TCIS_ADDR_W_PRI;
    assign ar = alt ? TCIS_ADDR_R_ALT : TCIS_ADDR_R_PRI;
    assign int_pull_out = rst_n_in && mem[0][TCIS_STAT_READY_BIT];

    initial
    begin
        {scl_pull_out, sda_pull_out, alt, ph, cnt, ptr} = '0;
        foreach (mem[k]) mem[k] = 8'h00;
    end

    always @(posedge rst_n_in) alt = int_in;
    always @(negedge rst_n_in)
    begin
        ph = 3'd0;
        foreach (mem[k]) mem[k] = 8'h00;
    end

    always @(negedge sda_in) if (scl_in === 1'b1 && rst_n_in)
    begin
        ph = 3'd1;
        cnt = 4'd0;
    end
    always @(posedge sda_in) if (scl_in === 1'b1) ph = 3'd0;

    always @(posedge scl_in) if (ph != 3'd0)
    begin
        if (cnt < 4'd8)
            sh = {sh[6:0], sda_in};
        else if (ph == 3'd5 && sda_in)
            ph = 3'd0;
        cnt = cnt + 4'd1;
    end

    always @(negedge scl_in) if (ph != 3'd0)
    begin
        if (cnt == 4'd8 && ph == 3'd5)
        begin
            sda_pull_out = 1'b0;
            ptr = ptr + 16'h0001;
        end
        else if (cnt == 4'd8)
        begin
            case (ph)
                3'd1: ph = (sh == aw) ? 3'd2 : (sh == ar) ? 3'd5 : 3'd0;
                3'd2: {ptr[15:8], ph} = {sh, 3'd3};
                3'd3: {ptr[7:0], ph} = {sh, 3'd4};
                default:
                begin
                    if (ptr == TCIS_REG_TOUCH_REPORT_STATUS) mem[0] = sh;
                    ptr = ptr + 16'h0001;
                end
            endcase
            if (mute_in) ph = 3'd0;
            sda_pull_out = (ph != 3'd0);
        end
        else if (cnt == 4'd9)
        begin
            cnt = 4'd0;
            sda_pull_out = 1'b0;
        end
        b = (ptr >= TCIS_REG_TOUCH_REPORT_STATUS && ptr <= TCIS_REG_RESERVED_AFTER_POINT)
            ? mem[ptr - TCIS_REG_TOUCH_REPORT_STATUS] : 8'h00;
        if (ph == 3'd5 && cnt < 4'd8) sda_pull_out = !b[3'd7 - cnt[2:0]];
        if (slow_in)
        begin
            scl_pull_out = 1'b1;
            scl_pull_out <= #500 1'b0;
        end
    end
endmodule // tcis_dev_model

// [testbench/tcis_host_tb_top.sv]
// tcis_host_tb_top: self-checking bench for the touch panel host
// assumes tcis_dev_model on the pins and the bound monitor
`timescale 1ns/1ps
module tcis_host_tb_top;
    import tcis_pkg::*;
    logic       clk_in, sys_rst_in, addr_sel_in, cmd_valid_in, mute, slow;
    tcis_cmd_t  cmd_in;
    logic [7:0] wr_data_in, rd_data_out, r;
    logic       cmd_ready_out, wr_next_out, rd_valid_out, done_out, nack_err_out, attn_out;
    logic       addr_alt_out, scl_out, scl_oe_out, sda_out, sda_oe_out, int_out, int_oe_out;
    logic       tp_rst_n_out, scl_pull, sda_pull, int_pull;
    wire        scl_w = !(scl_oe_out || scl_pull);
    wire        sda_w = !(sda_oe_out || sda_pull);
    wire        int_w = int_oe_out ? int_out : !int_pull;
    int         miscompares, n_tests, s, k;
    logic [31:0] seed;
    logic [7:0] expq[$], wq[$], regs[9];

    tcis_host #(.QUARTER_CYC(4), .POR_RST_CYC(10), .POR_HOLD_CYC(20)) i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_sel_in(addr_sel_in), .cmd_in(cmd_in),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .wr_data_in(wr_data_in),
        .wr_next_out(wr_next_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .done_out(done_out), .nack_err_out(nack_err_out), .attn_out(attn_out),
        .addr_alt_out(addr_alt_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .scl_in(scl_w),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .sda_in(sda_w), .int_out(int_out),
        .int_oe_out(int_oe_out), .int_in(int_w), .tp_rst_n_out(tp_rst_n_out));

    tcis_dev_model i_dev (.scl_in(scl_w), .sda_in(sda_w), .int_in(int_w), .rst_n_in(tp_rst_n_out),
        .scl_pull_out(scl_pull), .sda_pull_out(sda_pull), .int_pull_out(int_pull),
        .mute_in(mute), .slow_in(slow));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic run(input logic rd, input logic [15:0] a, input logic [7:0] n);
        int i;
        for (i = 0; i < 3000 && cmd_ready_out !== 1'b1; i++) @(negedge clk_in);
        if (i >= 3000)
        begin
            miscompares++;
            end_of_test();
        end
        if (wq.size() > 0) wr_data_in = wq.pop_front();
        cmd_in = '{rd, a, n};
        cmd_valid_in = 1'b1;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        for (i = 0; i < 20000 && done_out !== 1'b1; i++)
        begin
            @(negedge clk_in);
            if (wr_next_out === 1'b1 && wq.size() > 0) wr_data_in = wq.pop_front();
        end
        if (i >= 20000)
        begin
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic rd(input int first, input int n);
        for (int j = 0; j < n; j++) expq.push_back(regs[first + j]);
        run(1'b1, TCIS_REG_TOUCH_REPORT_STATUS + 16'(first), 8'(n));
    endtask

    always @(negedge clk_in)
        if (rd_valid_out === 1'b1)
            chk(rd_data_out, expq.size() > 0 ? expq.pop_front() : ~rd_data_out);

    initial
    begin
        {sys_rst_in, addr_sel_in, cmd_valid_in, mute, slow} = 5'b10000;
        cmd_in = '0;
        wr_data_in = 8'h00;
        miscompares = 0;
        n_tests = 0;
        seed = 82;
        for (s = 0; s < 2; s++)
        begin
            addr_sel_in = s[0];
            sys_rst_in = 1'b1;
            repeat (5) @(negedge clk_in);
            sys_rst_in = 1'b0;
            for (k = 0; k < 9; k++) regs[k] = (k > 0 && k < 8) ? rnd() : 8'h00;
            for (k = 0; k < 9; k++) i_dev.mem[k] = regs[k];
            regs[0] = rnd() & 8'h7f;
            wq = '{regs[0], ~regs[1]};
            run(1'b0, TCIS_REG_TOUCH_REPORT_STATUS, 8'd2);
            chk(8'(addr_alt_out), 8'(s));
            chk(8'({scl_out, sda_out}), 8'h00);
            chk(8'(i_dev.alt), 8'(s));
            rd(0, 9);
            chk(8'(nack_err_out), 8'h00);
            r = rnd();
            regs[0] = {1'b1, s[0], 2'b00, r[3:0]};
            i_dev.mem[0] = regs[0];
            repeat (8) @(negedge clk_in);
            chk(8'(attn_out), 8'h01);
            rd(0, 8);
            wq = '{8'h00};
            run(1'b0, TCIS_REG_TOUCH_REPORT_STATUS, 8'd1);
            repeat (8) @(negedge clk_in);
            chk(8'(attn_out), 8'h00);
            slow = 1'b1;
            rd(3, 2);
            slow = 1'b0;
            mute = 1'b1;
            run(1'b1, TCIS_REG_FIRST_POINT_X_LOW, 8'd3);
            chk(8'(nack_err_out), 8'h01);
            mute = 1'b0;
            cmd_in = '{1'b1, TCIS_REG_TOUCH_REPORT_STATUS, 8'h00};
            cmd_valid_in = 1'b1;
            repeat (3) @(negedge clk_in);
            chk(8'(cmd_ready_out), 8'h01);
            cmd_valid_in = 1'b0;
        end
        chk(8'(expq.size()), 8'h00);
        end_of_test();
    end
endmodule // tcis_host_tb_top
